// File: hw/hss_delay_timer.sv
// Purpose: Idle timer counting whole delay units of UNIT_CYCLES clocks.
// Assumes: start is a one-cycle pulse; units is sampled with it.
// Notes:   abort drops a running delay without an expiry pulse.
`timescale 1ns/1ps
`default_nettype none
module hss_delay_timer
    import hss_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [FIELD_W-1:0] units,
    output logic expired
);

    logic running;
    logic [FIELD_W-1:0] units_left;
    logic [31:0] tick_cnt;
    logic unit_end;

    assign unit_end = (tick_cnt == UNIT_CYCLES - 1);

    // Unit and tick counters; total idle is units * UNIT_CYCLES clocks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
            units_left <= '0;
            tick_cnt <= '0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                running <= (units != '0);
                expired <= (units == '0);
                units_left <= units;
                tick_cnt <= '0;
            end else if (running) begin
                if (unit_end) begin
                    tick_cnt <= '0;
                    units_left <= units_left - 7'h01;
                    if (units_left == 7'h01) begin
                        running <= 1'b0;
                        expired <= 1'b1;
                    end
                end else begin
                    tick_cnt <= tick_cnt + 32'h00000001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: hw/hss_pkg.sv
// Purpose: Shared constants, types and decode helpers for the haptic sequence slots.
// Assumes: Classic Wishbone, 32-bit data, one aligned word per register index.
// Notes:   Byte address of a register is four times its index.
//
// Overview of operation
// - Delay-select set: low seven bits are idle time, no waveform driven.
// - Delay slot idles 10 ms times its seven-bit value, then moves on; the sequencer stops at a zero value instead.
// - Delay-select clear: seven-bit field is a waveform identifier to play.
// - Identifier in bits six to zero indexes one waveform of the library.
// - Setting the go bit starts playback at the first slot.
// - After a waveform ends, play the following slot if it is non-zero.
// - Stop at a zero identifier or after eight slots, whichever first.
package hss_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SLOT_W = 8;
    localparam int FIELD_W = 7;
    localparam int SLOT_COUNT = 8;
    localparam int POS_W = 3;

    // ************************************************************
    // Register indices (byte address = index * 4)
    // ************************************************************
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] IDX_SLOT_FIRST = 8'h0F;
    localparam logic [ADDR_W-1:0] IDX_SLOT_THREE = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_SLOT_FOUR = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_SLOT_LAST = 8'h16;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h20;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_GO_BIT = 0;
    localparam int SLOT_DELAY_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DELAY_BIT = 1;
    localparam int STAT_PLAY_BIT = 2;
    localparam int STAT_POS_LSB = 4;
    localparam logic [SLOT_W-1:0] SLOT_RESET = 8'h00;
    localparam logic CONTROL_GO_RESET = 1'b0;
    localparam logic [POS_W-1:0] POS_LAST = 3'h7;

    // ************************************************************
    // Timing: one delay unit is 10 ms at a 4 ns clock
    // ************************************************************
    localparam longint DELAY_UNIT_NS = 10_000_000;
    localparam longint CLK_PERIOD_NS = 4;
    localparam int unsigned DELAY_UNIT_CYCLES = int'(DELAY_UNIT_NS / CLK_PERIOD_NS);

    // ************************************************************
    // Sequencer states, one-hot
    // ************************************************************
    typedef enum logic [4:0] {
        HSS_IDLE   = 5'h01,
        HSS_FETCH  = 5'h02,
        HSS_DECODE = 5'h04,
        HSS_PLAY   = 5'h08,
        HSS_DELAY  = 5'h10
    } hss_state_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] hss_byte_addr(input logic [ADDR_W-1:0] idx);
        hss_byte_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction

    // Byte address falls on one of the eight slots
    function automatic logic hss_is_slot(input logic [ADDR_W-1:0] adr);
        hss_is_slot = (adr[1:0] == 2'b00) && (adr >= hss_byte_addr(IDX_SLOT_FIRST))
                      && (adr <= hss_byte_addr(IDX_SLOT_LAST));
    endfunction

    // Slot position of a slot byte address
    function automatic logic [POS_W-1:0] hss_slot_pos(input logic [ADDR_W-1:0] adr);
        logic [ADDR_W-1:0] diff;
        diff = adr - hss_byte_addr(IDX_SLOT_FIRST);
        hss_slot_pos = diff[POS_W+1:2];
    endfunction

endpackage

// File: hw/hss_sequencer.sv
// Purpose: Wishbone register file and eight-slot playback sequencer.
// Assumes: wave_done pulses once when the library player finishes a waveform.
// Notes:   Slot reads and writes allowed during playback; a change is seen when fetched.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module hss_sequencer
    import hss_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wave_start,
    output logic wave_abort,
    output logic [FIELD_W-1:0] wave_index,
    input wire logic wave_done,
    output logic seq_busy,
    output logic seq_delay_active
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic req;
    logic pend;
    logic bus_commit;
    logic wr_commit;
    logic slot_hit;
    logic ctrl_hit;
    logic stat_hit;
    logic slot_wr_en;
    logic ctrl_wr;
    logic [POS_W-1:0] bus_pos;
    logic [SLOT_W-1:0] bus_slot_rdata;
    logic [SLOT_W-1:0] seq_slot_rdata;
    logic [DATA_W-1:0] next_rdata;
    logic go;
    hss_state_t state;
    hss_state_t next_state;
    logic [POS_W-1:0] pos;
    logic seq_end;
    logic step_done;
    logic timer_start;
    logic timer_expired;
    logic abort_req;
    logic entry_zero;
    logic entry_delay;

    // ************************************************************
    // Wishbone slave
    // ************************************************************

    // Request decode; address held by the master until ack
    assign req = wb_cyc_i && wb_stb_i;
    assign slot_hit = hss_is_slot(wb_adr_i);
    assign ctrl_hit = (wb_adr_i == hss_byte_addr(IDX_CONTROL));
    assign stat_hit = (wb_adr_i == hss_byte_addr(IDX_STATUS));
    assign bus_pos = hss_slot_pos(wb_adr_i);

    // The ack edge is the only edge at which a write lands
    assign bus_commit = req && pend;
    assign wr_commit = bus_commit && wb_we_i && wb_sel_i[0];
    assign slot_wr_en = wr_commit && slot_hit;
    assign ctrl_wr = wr_commit && ctrl_hit;

    // Two-cycle answer: one cycle for the registered slot read, one for ack
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            wb_ack_o <= 1'b0;
        end else begin
            pend <= req && !pend && !wb_ack_o;
            wb_ack_o <= bus_commit;
        end
    end

    // Read data mux; unmapped and reserved bits read as zero
    always_comb begin
        next_rdata = '0;
        if (slot_hit) begin
            next_rdata[SLOT_W-1:0] = bus_slot_rdata;
        end else if (ctrl_hit) begin
            next_rdata[CTRL_GO_BIT] = go;
        end else if (stat_hit) begin
            next_rdata[STAT_BUSY_BIT] = seq_busy;
            next_rdata[STAT_DELAY_BIT] = seq_delay_active;
            next_rdata[STAT_PLAY_BIT] = (state == HSS_PLAY);
            next_rdata[STAT_POS_LSB +: POS_W] = pos;
        end
    end

    // Read data registered at the ack edge, held until the next answer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (bus_commit && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ************************************************************
    // Slot storage
    // ************************************************************
    hss_slot_mem u_slots (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(slot_wr_en),
        .wr_pos(bus_pos),
        .wr_data(wb_dat_i[SLOT_W-1:0]),
        .bus_pos(bus_pos),
        .bus_rdata(bus_slot_rdata),
        .seq_pos(pos),
        .seq_rdata(seq_slot_rdata)
    );

    // ************************************************************
    // Go bit
    // ************************************************************

    // Software write beats the hardware clear, so a restart is never lost
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            go <= CONTROL_GO_RESET;
        end else if (ctrl_wr) begin
            go <= wb_dat_i[CTRL_GO_BIT];
        end else if (seq_end) begin
            go <= 1'b0;
        end
    end

    // Clearing go while busy abandons the sequence
    assign abort_req = !go && (state != HSS_IDLE) && (state != HSS_FETCH || pos != '0);

    // ************************************************************
    // Slot decode
    // ************************************************************

    // Zero identifier stops; a delay entry of zero stops as well
    assign entry_zero = (seq_slot_rdata[FIELD_W-1:0] == '0);
    assign entry_delay = seq_slot_rdata[SLOT_DELAY_BIT];

    // Step finished: waveform done or idle time over
    assign step_done = ((state == HSS_PLAY) && wave_done)
                       || ((state == HSS_DELAY) && timer_expired);

    // End of sequence: zero entry, or the eighth slot completed
    always_comb begin
        seq_end = 1'b0;
        if (state == HSS_DECODE && entry_zero) begin
            seq_end = 1'b1;
        end else if (step_done && pos == POS_LAST) begin
            seq_end = 1'b1;
        end
    end

    // ************************************************************
    // Sequencer state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            HSS_IDLE: begin
                if (go) begin
                    next_state = HSS_FETCH;
                end
            end
            HSS_FETCH: begin
                next_state = HSS_DECODE;
            end
            HSS_DECODE: begin
                if (entry_zero) begin
                    next_state = HSS_IDLE;
                end else if (entry_delay) begin
                    next_state = HSS_DELAY;
                end else begin
                    next_state = HSS_PLAY;
                end
            end
            HSS_PLAY, HSS_DELAY: begin
                if (seq_end) begin
                    next_state = HSS_IDLE;
                end else if (step_done) begin
                    next_state = HSS_FETCH;
                end
            end
            default: begin
                next_state = HSS_IDLE;
            end
        endcase
        if (abort_req) begin
            next_state = HSS_IDLE;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= HSS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Slot position: first slot on start, one step per finished slot
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pos <= '0;
        end else if (state == HSS_IDLE) begin
            pos <= '0;
        end else if (step_done && !seq_end) begin
            pos <= pos + 3'h1;
        end
    end

    // ************************************************************
    // Playback and delay outputs
    // ************************************************************

    // Waveform request carries the identifier as a library index
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wave_start <= 1'b0;
            wave_index <= '0;
        end else begin
            wave_start <= 1'b0;
            if (state == HSS_DECODE && !entry_zero && !entry_delay && !abort_req) begin
                wave_start <= 1'b1;
                wave_index <= seq_slot_rdata[FIELD_W-1:0];
            end
        end
    end

    // Tell the player to stop if software abandons a waveform mid-play
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wave_abort <= 1'b0;
        end else begin
            wave_abort <= abort_req && (state == HSS_PLAY);
        end
    end

    // Delay entry loads the timer; no waveform is driven meanwhile
    assign timer_start = (state == HSS_DECODE) && !entry_zero && entry_delay;

    hss_delay_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(timer_start),
        .abort(abort_req),
        .units(seq_slot_rdata[FIELD_W-1:0]),
        .expired(timer_expired)
    );

    // Status levels
    assign seq_busy = (state != HSS_IDLE);
    assign seq_delay_active = (state == HSS_DELAY);

endmodule
`default_nettype wire

// File: hw/hss_slot_mem.sv
// Purpose: Eight sequence slots with one write port and two registered read ports.
// Assumes: Write and reads share sys_clk; reads see the value before a same-edge write.
// Notes:   Bus port serves software, sequencer port serves playback.
`timescale 1ns/1ps
`default_nettype none
module hss_slot_mem
    import hss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [POS_W-1:0] wr_pos,
    input wire logic [SLOT_W-1:0] wr_data,
    input wire logic [POS_W-1:0] bus_pos,
    output logic [SLOT_W-1:0] bus_rdata,
    input wire logic [POS_W-1:0] seq_pos,
    output logic [SLOT_W-1:0] seq_rdata
);

    logic [SLOT_W-1:0] slots [SLOT_COUNT];

    // Slot storage, all entries clear at reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slots[i] <= SLOT_RESET;
            end
        end else if (wr_en) begin
            slots[wr_pos] <= wr_data;
        end
    end

    // Registered read ports
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= SLOT_RESET;
            seq_rdata <= SLOT_RESET;
        end else begin
            bus_rdata <= slots[bus_pos];
            seq_rdata <= slots[seq_pos];
        end
    end

endmodule
`default_nettype wire

// File: test/hss_sequencer_checker.sv
// Purpose: Port-level assertions for the haptic sequence slots.
// Assumes: Single sys_clk domain, asynchronous active-high rst.
// Notes:   Sees only the ports of hss_sequencer.
`timescale 1ns/1ps
`default_nettype none
module hss_sequencer_checker
    import hss_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wave_start,
    input wire logic wave_abort,
    input wire logic [FIELD_W-1:0] wave_index,
    input wire logic seq_busy,
    input wire logic seq_delay_active
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Start-up: fetch and decode precede any outcome
    sequence s_fetch_decode;
        ##[1:3] (wave_start || seq_delay_active || !seq_busy);
    endsequence

    property p_ack_two;
        $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##2 wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_start_pulse;
        wave_start |=> !wave_start;
    endproperty
    property p_delay_quiet;
        seq_delay_active |-> !wave_start && seq_busy;
    endproperty
    property p_start_busy;
        wave_start |-> seq_busy;
    endproperty
    property p_index_hold;
        !wave_start |-> $stable(wave_index);
    endproperty
    property p_go_start;
        $rose(seq_busy) |-> s_fetch_decode;
    endproperty
    property p_abort_idle;
        wave_abort |-> !seq_busy && !wave_start;
    endproperty

    a_ack_two: assert property (p_ack_two) else $error("ack not two cycles after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
    a_delay_quiet: assert property (p_delay_quiet) else $error("waveform during delay");
    a_start_busy: assert property (p_start_busy) else $error("start while idle");
    a_index_hold: assert property (p_index_hold) else $error("index moved without start");
    a_go_start: assert property (p_go_start) else $error("no outcome after go");
    a_abort_idle: assert property (p_abort_idle) else $error("abort pulse while still running");
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: Self-checking bench for hss_sequencer.
// Assumes: Wishbone ack two cycles after request; short delay unit.
// Notes:   UNIT_CYCLES shrunk so delay slots finish quickly.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import hss_pkg::*;
;
    localparam int unsigned U = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [DATA_W-1:0] wb_dat_i = 32'h0;
    logic [DATA_W-1:0] wb_dat_o;
    logic wb_ack_o, wave_start, wave_abort, seq_busy, seq_delay_active;
    logic [FIELD_W-1:0] wave_index;
    logic wave_done = 1'b0;
    logic [DATA_W-1:0] q;
    int n_fail = 0;
    int total_checks = 0;
    int n_abort = 0;

    hss_sequencer #(.UNIT_CYCLES(U)) u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wave_start(wave_start),
        .wave_abort(wave_abort), .wave_index(wave_index), .wave_done(wave_done),
        .seq_busy(seq_busy), .seq_delay_active(seq_delay_active));

    // ****************************************
    // Shared tasks
    // ****************************************
    always #2 sys_clk = ~sys_clk;

    // Abort pulses counted for the abort scenario
    always @(posedge sys_clk) begin
        if (wave_abort === 1'b1) begin
            n_abort <= n_abort + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One classic cycle; waits for ack, only the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Wait for a start pulse; returns cycles spent in delay meanwhile
    task automatic play(input logic [6:0] idx, output int dly);
        int n = 0;
        dly = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (seq_delay_active === 1'b1) dly++;
        end while (wave_start !== 1'b1 && n < 2000);
        check(wave_start, 1'b1);
        check({25'h0, wave_index}, {25'h0, idx});
        wave_done <= 1'b1;
        @(posedge sys_clk);
        wave_done <= 1'b0;
    endtask

    // Sequence must stop with no further start
    task automatic expect_stop();
        int s = 0;
        repeat (12) begin
            @(posedge sys_clk);
            if (wave_start === 1'b1) s++;
        end
        check(s, 0);
        check(seq_busy, 1'b0);
        wb(1'b0, 8'h30, 32'h0);
        check(q, 32'h0);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, read back, unmapped place
    task automatic t_regs();
        wb(1'b0, 8'h44, 32'h0);
        check(q, 32'h0);
        wb(1'b0, 8'h48, 32'h0);
        check(q, 32'h0);
        wb(1'b1, 8'h44, 32'hFFFF_FFA5);
        wb(1'b1, 8'h48, 32'h0000_005A);
        wb(1'b0, 8'h44, 32'h0);
        check(q, 32'hA5);
        wb(1'b0, 8'h48, 32'h0);
        check(q, 32'h5A);
        wb(1'b0, 8'hFC, 32'h0);
        check(q, 32'h0);
    endtask

    // Waves, a delay in slot three, stop at a zero in slot five
    task automatic t_delay();
        int d;
        wb(1'b1, 8'h3C, 32'h05);
        wb(1'b1, 8'h40, 32'h20);
        wb(1'b1, 8'h44, 32'h83);
        wb(1'b1, 8'h48, 32'h11);
        wb(1'b1, 8'h4C, 32'h00);
        wb(1'b1, 8'h30, 32'h01);
        play(7'h05, d);
        check(d, 0);
        play(7'h20, d);
        play(7'h11, d);
        check(d >= 3 * U && d <= 3 * U + 2, 1'b1);
        expect_stop();
    endtask

    // All eight slots hold waves: stop after the eighth
    task automatic t_eight();
        int d;
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h3C + 8'(4 * i), 32'(i + 1));
        end
        wb(1'b1, 8'h30, 32'h01);
        for (int i = 0; i < 8; i++) begin
            play(7'(i + 1), d);
        end
        expect_stop();
    endtask

    // Status while playing and delaying; clearing go abandons either
    task automatic t_abort();
        int n;
        int d;
        wb(1'b1, 8'h3C, 32'h07);
        wb(1'b1, 8'h40, 32'h82);
        wb(1'b1, 8'h30, 32'h01);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wave_start !== 1'b1 && n < 20);
        check(wave_start, 1'b1);
        wb(1'b0, 8'h80, 32'h0);
        check(q, (32'h1 << STAT_BUSY_BIT) | (32'h1 << STAT_PLAY_BIT));
        wb(1'b1, 8'h30, 32'h00);
        expect_stop();
        check(n_abort, 1);
        wb(1'b1, 8'h30, 32'h01);
        play(7'h07, d);
        n = 0;
        while (seq_delay_active !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check(seq_delay_active, 1'b1);
        wb(1'b0, 8'h80, 32'h0);
        check(q, (32'h1 << STAT_BUSY_BIT) | (32'h1 << STAT_DELAY_BIT) | (32'h1 << STAT_POS_LSB));
        check(wave_start, 1'b0);
        wb(1'b1, 8'h30, 32'h00);
        expect_stop();
        check(n_abort, 1);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_delay();
        t_eight();
        t_abort();
        close_out();
    end

    // Whole run is a few hundred cycles
    initial begin
        #40000;
        n_fail++;
        close_out();
    end
endmodule

bind hss_sequencer hss_sequencer_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.sys_clk(sys_clk),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wave_start(wave_start), .wave_abort(wave_abort), .wave_index(wave_index), .seq_busy(seq_busy),
    .seq_delay_active(seq_delay_active));
`default_nettype wire
